//--- sim/eight_bit_prescaled_counter_test.sv
// Self-checking bench of the prescaled counter through its APB registers.
// Assumes counter_pkg, the design under verilog/ and pin_source_model.
module eight_bit_prescaled_counter_test import counter_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [ADDR_W-1:0] PADDR = '0;
    logic [DATA_W-1:0] PWDATA = '0;
    logic [DATA_W-1:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic IRQ;
    logic pin;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [DATA_W-1:0] v;
    logic [DATA_W-1:0] v0;
    logic e;
    int t0;
    int t1;
    int div [5] = '{1, 8, 64, 256, 1024};
    logic [ADDR_W-1:0] regs [4] = '{ADDR_CTRL, ADDR_CNT, ADDR_FLAG, ADDR_MASK};

    // ************************************************************
    // Clock, cycle index and instances
    // ************************************************************
    always #2.5 CLOCK = ~CLOCK;

    // Cycle index lets timing checks be measured, not assumed.
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
    end

    prescaled_counter dut_u (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .EXTERNAL_COUNT_PIN(pin), .IRQ(IRQ));

    pin_source_model src_u (.clock(CLOCK), .pin(pin));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic stop_test();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [DATA_W-1:0] ex, input logic [DATA_W-1:0] got);
        tests_run++;
        if (got !== ex) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, ex, got);
        end
    endtask

    // One APB transfer; ready is looked at right after each rising edge,
    // before that edge's own updates land, so it is what the slave sampled.
    task automatic xfer(input logic we, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
        output logic [DATA_W-1:0] rd, output logic err, output int t);
        int n;
        n = 0;
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= we;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLOCK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1) begin
            chk("pready", 1, 0);
            stop_test();
        end
        rd = PRDATA;
        err = PSLVERR;
        t = cyc;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    // The interrupt is a flop: look one edge after the access that moves it.
    task automatic irq_chk(input string nm, input logic ex);
        @(posedge CLOCK);
        chk(nm, 32'(ex), 32'(IRQ));
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        xfer(1'b1, a, d, v, e, t0);
    endtask

    task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
        xfer(1'b0, a, '0, v, e, t0);
        chk(nm, ex, v);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (5) @(posedge CLOCK);
        RST <= 1'b0;
        foreach (regs[i]) rd_chk("reset", regs[i], 0);
        irq_chk("irq", 1'b0);
        wr(ADDR_CTRL, 32'hFFFF_FFF8);
        rd_chk("ctrl", ADDR_CTRL, 0);
        wr(ADDR_CNT, 32'h1A5);
        repeat (40) @(posedge CLOCK);
        rd_chk("count", ADDR_CNT, 32'hA5);
        xfer(1'b0, 8'hD0, '0, v, e, t0);
        chk("slverr", 1, 32'(e));
        // Each divider: the two snapshots are four periods apart, and a
        // free-running prescaler gives exactly one tick in every period.
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_CTRL, i + 1);
            xfer(1'b0, ADDR_CNT, '0, v0, e, t0);
            repeat (4 * div[i] - 4) @(posedge CLOCK);
            xfer(1'b0, ADDR_CNT, '0, v, e, t1);
            v = (v - v0) & 32'hFF;
            chk("rate", 32'((t1 - t0) / div[i]), v);
        end
        // Write while running: counting resumes in the next cycle.
        wr(ADDR_CTRL, CS_DIV1);
        xfer(1'b1, ADDR_CNT, 32'h10, v, e, t0);
        xfer(1'b0, ADDR_CNT, '0, v, e, t1);
        chk("resume", (32'h10 + t1 - 2 - t0) & 32'hFF, v);
        // Overflow, mask and clear.
        wr(ADDR_CTRL, CS_STOP);
        wr(ADDR_FLAG, 1);
        wr(ADDR_MASK, 1);
        wr(ADDR_CNT, 32'hFE);
        wr(ADDR_CTRL, CS_DIV1);
        wr(ADDR_CTRL, CS_STOP);
        irq_chk("irq", 1'b1);
        rd_chk("flag", ADDR_FLAG, 1);
        wr(ADDR_MASK, 0);
        irq_chk("irq", 1'b0);
        rd_chk("flag", ADDR_FLAG, 1);
        wr(ADDR_MASK, 1);
        wr(ADDR_FLAG, 1);
        irq_chk("irq", 1'b0);
        rd_chk("flag", ADDR_FLAG, 0);
        // Pin modes: five toggles from low give three rises, two falls.
        wr(ADDR_CNT, 0);
        wr(ADDR_CTRL, CS_EXT_RISE);
        src_u.toggle(5, 1);
        repeat (6) @(posedge CLOCK);
        rd_chk("rise", ADDR_CNT, 3);
        wr(ADDR_CNT, 0);
        wr(ADDR_CTRL, CS_EXT_FALL);
        src_u.toggle(5, 3);
        repeat (6) @(posedge CLOCK);
        rd_chk("fall", ADDR_CNT, 3);
        wr(ADDR_CTRL, CS_STOP);
        src_u.toggle(4, 2);
        repeat (6) @(posedge CLOCK);
        rd_chk("stop", ADDR_CNT, 3);
        stop_test();
    end
endmodule

//--- sim/pin_source_model.sv
// Event source that stands at the far side of the external count pin.
// Assumes the bench calls toggle from its main sequence, one call at a time.
module pin_source_model (
    input wire logic clock,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Pin driver
    // ************************************************************
    // The pin idles low until the first toggle.
    initial begin
        pin = 1'b0;
    end

    // Changes land just after a rising edge, a full period before the next sample.
    // edges gap periods apart.
    task automatic toggle(input int n, input int gap);
        repeat (n) begin
            repeat (gap) @(posedge clock);
            pin <= ~pin;
        end
    endtask
endmodule

//--- verilog/counter_pkg.sv
// Shared constants, register map and clock-select codes of the prescaled
// eight-bit counter.
// Assumes an APB3 master with 32-bit data and byte addresses of eight bits.
package counter_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 8;
    localparam int CS_W = 3;
    localparam int PRE_W = 10;
    localparam int NUM_TAPS = 4;
    localparam int SYNC_STAGES = 3;

    // Prescaler taps: divide by 8, 64, 256 and 1024 (two to these powers).
    localparam int TAP_BITS [NUM_TAPS] = '{3, 6, 8, 10};

    // ************************************************************
    // Register map: indices, byte address is four times the index
    // ************************************************************
    localparam int IDX_CTRL = 'h33;
    localparam int IDX_CNT = 'h32;
    localparam int IDX_FLAG = 'h38;
    localparam int IDX_MASK = 'h39;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = ADDR_W'(IDX_CTRL * 4);
    localparam logic [ADDR_W-1:0] ADDR_CNT = ADDR_W'(IDX_CNT * 4);
    localparam logic [ADDR_W-1:0] ADDR_FLAG = ADDR_W'(IDX_FLAG * 4);
    localparam logic [ADDR_W-1:0] ADDR_MASK = ADDR_W'(IDX_MASK * 4);

    // Field positions and reset values.
    localparam int OVF_BIT = 0;
    localparam logic [CS_W-1:0] CTRL_RST = 3'h0;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic FLAG_RST = 1'b0;
    localparam logic MASK_RST = 1'b0;

    // ************************************************************
    // Clock-select codes
    // ************************************************************
    localparam logic [CS_W-1:0] CS_STOP = 3'h0;
    localparam logic [CS_W-1:0] CS_DIV1 = 3'h1;
    localparam logic [CS_W-1:0] CS_DIV8 = 3'h2;
    localparam logic [CS_W-1:0] CS_DIV64 = 3'h3;
    localparam logic [CS_W-1:0] CS_DIV256 = 3'h4;
    localparam logic [CS_W-1:0] CS_DIV1024 = 3'h5;
    localparam logic [CS_W-1:0] CS_EXT_FALL = 3'h6;
    localparam logic [CS_W-1:0] CS_EXT_RISE = 3'h7;

    // Which register an address selects.
    typedef enum {SEL_NONE, SEL_CTRL, SEL_CNT, SEL_FLAG, SEL_MASK} reg_sel_e;

endpackage

//--- verilog/pin_edge_sync.sv
// Three-flop synchroniser and edge detector for the external count pin.
// Assumes the pin is asynchronous and its transitions are at least one
// clock period apart, so no edge is missed.
module pin_edge_sync (
    input wire logic clock,
    input wire logic rst,
    input wire logic pin,
    output logic rise,
    output logic fall
);
    import counter_pkg::*;

    logic [SYNC_STAGES-1:0] sync_r;
    logic [SYNC_STAGES-1:0] sync_nxt;

    // sample on each rising clock edge.
    always_comb begin
        sync_nxt = {sync_r[SYNC_STAGES-2:0], pin};
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sync_r <= '0;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    // edge pulses from stages two and three.
    // Stage one is left to the second flop alone to contain metastability.
    assign rise = sync_r[1] & ~sync_r[2];
    assign fall = ~sync_r[1] & sync_r[2];

    AST_RISE_FROM_PIN: assert property (@(posedge clock) disable iff (rst)
        rise |-> $past(pin, 2) && !$past(pin, 3))
        else $error("rise pulse without a sampled rising pin");

    AST_FALL_FROM_PIN: assert property (@(posedge clock) disable iff (rst)
        fall |-> !$past(pin, 2) && $past(pin, 3))
        else $error("fall pulse without a sampled falling pin");

endmodule

//--- verilog/prescale_divider.sv
// Free-running ten-bit prescaler giving one-cycle tick enables.
// Assumes the same clock and synchronous reset as the counter that uses it.
module prescale_divider (
    input wire logic clock,
    input wire logic rst,
    output logic [counter_pkg::NUM_TAPS-1:0] tap_tick
);
    import counter_pkg::*;

    logic [PRE_W-1:0] pre_r;
    logic [PRE_W-1:0] pre_nxt;

    // The prescaler never stops, so tick phase does not depend on the select.
    always_comb begin
        pre_nxt = pre_r + 10'h001;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_nxt;
        end
    end

    for (genvar g = 0; g < NUM_TAPS; g++) begin : gen_tap
        assign tap_tick[g] = &pre_r[TAP_BITS[g]-1:0];
    end

    AST_TICK8_PERIOD: assert property (@(posedge clock) disable iff (rst)
        tap_tick[0] |=> !tap_tick[0] [*7] ##1 tap_tick[0])
        else $error("divide-by-8 tick not every eight cycles");

    AST_TICK1024_ALIGN: assert property (@(posedge clock) disable iff (rst)
        tap_tick[3] |-> (pre_r == 10'h3FF) && tap_tick[2] && tap_tick[1] && tap_tick[0])
        else $error("divide-by-1024 tick misaligned");

endmodule

//--- verilog/prescaled_counter.sv
// Eight-bit prescaled up-counter with APB register access and an overflow
// interrupt.
// Assumes an APB3 master on CLOCK, a synchronous active-high RST and an
// asynchronous external count pin.
//
// What this block does
// - Eight-bit up-counter, readable and writable anytime.
// - Free-running ten-bit prescaler from oscillator clock.
// - Codes 0-5 select stop, 1, 8, 64, 256, 1024.
// - Code 6 falling, code 7 rising pin edges.
// - Select in bits 2:0; bits above read zero.
// - Pin sampled on each rising clock edge.
// - Pin counted even when driven as output.
// - Written value counts on from next cycle.
// - Overflow flag plus enable in mask register.
module prescaled_counter (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [counter_pkg::ADDR_W-1:0] PADDR,
    input wire logic [counter_pkg::DATA_W-1:0] PWDATA,
    output logic [counter_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic EXTERNAL_COUNT_PIN,
    output logic IRQ
);
    import counter_pkg::*;

    // ************************************************************
    // Address decode
    // ************************************************************

    // Shared by the read path, the write path and the error answer.
    function automatic reg_sel_e decode(input logic [ADDR_W-1:0] addr);
        reg_sel_e sel;
        sel = SEL_NONE;
        if (addr == ADDR_CTRL) begin
            sel = SEL_CTRL;
        end else if (addr == ADDR_CNT) begin
            sel = SEL_CNT;
        end else if (addr == ADDR_FLAG) begin
            sel = SEL_FLAG;
        end else if (addr == ADDR_MASK) begin
            sel = SEL_MASK;
        end
        return sel;
    endfunction

    // ************************************************************
    // Tick sources
    // ************************************************************

    logic [NUM_TAPS-1:0] tap_tick;
    logic pin_rise;
    logic pin_fall;

    prescale_divider u_prescale (
        .clock(CLOCK),
        .rst(RST),
        .tap_tick(tap_tick)
    );

    // The pin input is the pad level itself, so a value driven out by
    // software on the shared port pin is counted like any outside edge.
    // pad level counted.
    pin_edge_sync u_pin_sync (
        .clock(CLOCK),
        .rst(RST),
        .pin(EXTERNAL_COUNT_PIN),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // ************************************************************
    // State
    // ************************************************************

    logic [CS_W-1:0] ctrl_r;
    logic [CS_W-1:0] ctrl_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic flag_r;
    logic flag_nxt;
    logic mask_r;
    logic mask_nxt;
    logic [DATA_W-1:0] prdata_r;
    logic [DATA_W-1:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic irq_r;
    logic irq_nxt;

    logic access;
    logic first_access;
    logic commit;
    reg_sel_e sel;
    logic cnt_wr;
    logic cnt_tick;
    logic overflow;

    // Bus phase decode; one wait state, commit on the second access cycle.
    assign sel = decode(PADDR);
    assign access = PSEL & PENABLE;
    assign first_access = access & ~pready_r;
    assign commit = access & pready_r;
    assign cnt_wr = commit & PWRITE & (sel == SEL_CNT);

    always_comb begin
        case (ctrl_r)
            CS_STOP: cnt_tick = 1'b0;
            CS_DIV1: cnt_tick = 1'b1;
            CS_DIV8: cnt_tick = tap_tick[0];
            CS_DIV64: cnt_tick = tap_tick[1];
            CS_DIV256: cnt_tick = tap_tick[2];
            CS_DIV1024: cnt_tick = tap_tick[3];
            CS_EXT_FALL: cnt_tick = pin_fall;
            CS_EXT_RISE: cnt_tick = pin_rise;
            default: cnt_tick = 1'b0;
        endcase
    end

    // wrap detect.
    // A write in the same cycle wins, so the written value is not lost.
    assign overflow = cnt_tick & (cnt_r == CNT_MAX) & ~cnt_wr;

    // ************************************************************
    // Next-state logic
    // ************************************************************

    // All register and bus answer updates; set of the flag beats its clear.
    always_comb begin
        ctrl_nxt = ctrl_r;
        cnt_nxt = cnt_r;
        flag_nxt = flag_r;
        mask_nxt = mask_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        pready_nxt = first_access;

        // Read data and error are prepared in the wait cycle and register on the same edge as PREADY.
        if (first_access) begin
            pslverr_nxt = (sel == SEL_NONE);
            prdata_nxt = '0;
            if (!PWRITE) begin
                if (sel == SEL_CTRL) begin
                    prdata_nxt[CS_W-1:0] = ctrl_r;
                end else if (sel == SEL_CNT) begin
                    prdata_nxt[CNT_W-1:0] = cnt_r;
                end else if (sel == SEL_FLAG) begin
                    prdata_nxt[OVF_BIT] = flag_r;
                end else if (sel == SEL_MASK) begin
                    prdata_nxt[OVF_BIT] = mask_r;
                end
            end
        end else if (!access) begin
            pslverr_nxt = 1'b0;
        end

        // only the select field is writable.
        if (commit && PWRITE && (sel == SEL_CTRL)) begin
            ctrl_nxt = PWDATA[CS_W-1:0];
        end
        if (commit && PWRITE && (sel == SEL_MASK)) begin
            mask_nxt = PWDATA[OVF_BIT];
        end

        if (cnt_wr) begin
            cnt_nxt = PWDATA[CNT_W-1:0];
        end else if (cnt_tick) begin
            cnt_nxt = cnt_r + CNT_ONE;
        end

        if (commit && PWRITE && (sel == SEL_FLAG) && PWDATA[OVF_BIT]) begin
            flag_nxt = 1'b0;
        end
        if (overflow) begin
            flag_nxt = 1'b1;
        end

        irq_nxt = flag_nxt & mask_nxt;
    end

    // ************************************************************
    // Registers
    // ************************************************************

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ctrl_r <= CTRL_RST;
            cnt_r <= CNT_RST;
            flag_r <= FLAG_RST;
            mask_r <= MASK_RST;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            cnt_r <= cnt_nxt;
            flag_r <= flag_nxt;
            mask_r <= mask_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Every output comes straight from a flop.
    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign IRQ = irq_r;

    // ************************************************************
    // Checks
    // ************************************************************

    AST_CTRL_READ_UPPER_ZERO: assert property (@(posedge CLOCK) disable iff (RST)
        first_access && !PWRITE && (sel == SEL_CTRL) |=> PRDATA[DATA_W-1:CS_W] == '0)
        else $error("control read shows nonzero upper bits");

    AST_STOP_HOLDS: assert property (@(posedge CLOCK) disable iff (RST)
        (ctrl_r == CS_STOP) && !cnt_wr |=> $stable(cnt_r))
        else $error("counter moved while stopped");

    AST_UNDIVIDED_COUNT: assert property (@(posedge CLOCK) disable iff (RST)
        (ctrl_r == CS_DIV1) && !cnt_wr |=> cnt_r == CNT_W'($past(cnt_r) + CNT_ONE))
        else $error("undivided mode did not count every cycle");

    AST_DIV8_COUNT: assert property (@(posedge CLOCK) disable iff (RST)
        (ctrl_r == CS_DIV8) && !cnt_wr && !tap_tick[0] |=> $stable(cnt_r))
        else $error("divide-by-8 mode counted off its tick");

    AST_EXT_FALL_COUNT: assert property (@(posedge CLOCK) disable iff (RST)
        (ctrl_r == CS_EXT_FALL) && pin_fall && !cnt_wr |=> cnt_r == CNT_W'($past(cnt_r) + CNT_ONE))
        else $error("falling pin edge not counted");

    AST_WRITE_THEN_COUNT: assert property (@(posedge CLOCK) disable iff (RST)
        cnt_wr ##1 (ctrl_r == CS_DIV1) && !cnt_wr |=> cnt_r == CNT_W'($past(PWDATA[CNT_W-1:0], 2) + CNT_ONE))
        else $error("counting did not resume from written value");

    AST_WRAP_SETS_FLAG: assert property (@(posedge CLOCK) disable iff (RST)
        overflow |=> (cnt_r == CNT_RST) && flag_r)
        else $error("wrap from FF did not clear count and set flag");

    AST_IRQ_FOLLOWS_MASK: assert property (@(posedge CLOCK) disable iff (RST)
        IRQ == (flag_r && mask_r))
        else $error("interrupt does not follow enabled flag");

    // Checked on the release edge itself, so no sampled history from before
    // time zero can make it fire.
    AST_RESET_STOPPED: assert property (@(posedge CLOCK)
        RST ##1 !RST |-> (ctrl_r == CS_STOP) && (cnt_r == CNT_RST) && !IRQ)
        else $error("control not zero after reset");

    // Bus answer shape: one wait state and a one-cycle ready pulse, which the
    // master relies on before it releases its request.
    AST_READY_ONE_WAIT: assert property (@(posedge CLOCK) disable iff (RST)
        first_access |=> PREADY)
        else $error("ready not raised after one wait state");

    AST_READY_PULSE: assert property (@(posedge CLOCK) disable iff (RST)
        PREADY |=> !PREADY)
        else $error("ready held for more than one cycle");

    AST_UNMAPPED_ERROR: assert property (@(posedge CLOCK) disable iff (RST)
        commit && (sel == SEL_NONE) |-> PSLVERR)
        else $error("unmapped address answered without error");

    AST_CTRL_WRITE_FIELD: assert property (@(posedge CLOCK) disable iff (RST)
        commit && PWRITE && (sel == SEL_CTRL) |=> ctrl_r == $past(PWDATA[CS_W-1:0]))
        else $error("control write did not land in the select field");

    AST_DIV256_COUNT: assert property (@(posedge CLOCK) disable iff (RST)
        (ctrl_r == CS_DIV256) && !cnt_wr && !tap_tick[2] |=> $stable(cnt_r))
        else $error("divide-by-256 mode counted off its tick");

    AST_DIV1024_COUNT: assert property (@(posedge CLOCK) disable iff (RST)
        (ctrl_r == CS_DIV1024) && !cnt_wr && !tap_tick[3] |=> $stable(cnt_r))
        else $error("divide-by-1024 mode counted off its tick");

    AST_EXT_RISE_COUNT: assert property (@(posedge CLOCK) disable iff (RST)
        (ctrl_r == CS_EXT_RISE) && pin_rise && !cnt_wr |=> cnt_r == CNT_W'($past(cnt_r) + CNT_ONE))
        else $error("rising pin edge not counted");

    AST_FLAG_CLEARED: assert property (@(posedge CLOCK) disable iff (RST)
        commit && PWRITE && (sel == SEL_FLAG) && PWDATA[OVF_BIT] && !overflow |=> !flag_r)
        else $error("flag not cleared by writing one");

    AST_WRAP_RAISES_IRQ: assert property (@(posedge CLOCK) disable iff (RST)
        overflow && mask_nxt |=> IRQ)
        else $error("enabled wrap did not raise the interrupt");

endmodule
